// ==== logic/adcsr_pkg.sv ====
package adcsr_pkg;

  // ****************************************************************
  // widths and transfer shapes
  // ****************************************************************
  localparam int RES_BITS  = 12;
  localparam int BYTE_BITS = 8;
  localparam int CLK_FALL  = 12;
  localparam int CLK_RISE  = 13;
  localparam int CLK_BYTE  = 16;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYS_PERIOD_NS = 10;
  localparam int QUIET_TIME_NS = 8000;
  // longest time, so rounded down
  localparam int QUIET_CYC     = QUIET_TIME_NS / SYS_PERIOD_NS;
  localparam int HOST_HALF     = 4;
  localparam int CONVERT_START_N_LOW_CYC  = 4;
  localparam int BYTE_GAP_CYC  = 8;
  localparam int CONVERT_START_N_CYC_DEF  = 1000;
  localparam int FIFO_DEPTH    = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic BUSY_RST = 1'b1;
  localparam logic CONVERT_START_N_RST = 1'b1;
  localparam logic SCLK_RST = 1'b0;

  // msb-first bit pick from a result word
  function automatic logic result_bit(input logic [RES_BITS-1:0] word,
                                      input logic [3:0]          idx);
    result_bit = word[4'(RES_BITS - 1) - idx];
  endfunction

endpackage

// ==== logic/adcsr_if.sv ====
`timescale 1ns/1ps
interface adcsr_if;
  logic shift_clock_pin;
  logic serial_result_out;
  logic busy;
  logic convert_start_n;

  modport device (
    input  shift_clock_pin,
    input  convert_start_n,
    output serial_result_out,
    output busy
  );

  modport host (
    output shift_clock_pin,
    output convert_start_n,
    input  serial_result_out,
    input  busy
  );
endinterface

// ==== logic/adcsr_device.sv ====
`timescale 1ns/1ps
module adcsr_device #(
  parameter int CONVERT_START_N_CYCLES = adcsr_pkg::CONVERT_START_N_CYC_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clock_source_select,
  input  wire logic [11:0] convert_start_n_sample,
  output logic             convert_start_n_done,
  adcsr_if.device          link
);

  typedef enum logic {DV_IDLE, DV_CONVERT_START_N} adcsr_dev_state_type;

  // ****************************************************************
  // pin synchronisers (system domain)
  // ****************************************************************
  logic convert_start_n_meta_q, convert_start_n_sync_q, convert_start_n_prev_q;
  logic sel_meta_q, sel_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      convert_start_n_meta_q <= adcsr_pkg::CONVERT_START_N_RST;
      convert_start_n_sync_q <= adcsr_pkg::CONVERT_START_N_RST;
      convert_start_n_prev_q <= adcsr_pkg::CONVERT_START_N_RST;
      sel_meta_q  <= 1'b0;
      sel_q       <= 1'b0;
    end else begin
      convert_start_n_meta_q <= link.convert_start_n;
      convert_start_n_sync_q <= convert_start_n_meta_q;
      convert_start_n_prev_q <= convert_start_n_sync_q;
      sel_meta_q  <= clock_source_select;
      sel_q       <= sel_meta_q;
    end
  end

  wire convert_start_n_fall = convert_start_n_prev_q & ~convert_start_n_sync_q;

  // ****************************************************************
  // conversion timing
  // ****************************************************************
  adcsr_dev_state_type st_q;
  logic [15:0]         cnt_q;
  logic                busy_q;
  logic [11:0]         result_q;
  logic                clr_q;
  logic                done_q;

  wire convert_start_n_end = (st_q == DV_CONVERT_START_N) && (cnt_q == 16'(CONVERT_START_N_CYCLES - 1));
  wire convert_start_n_go  = (st_q == DV_IDLE) && convert_start_n_fall;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q  <= DV_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      case (st_q)
        DV_IDLE: begin
          cnt_q <= 16'h0000;
          if (convert_start_n_fall) begin
            st_q <= DV_CONVERT_START_N;
          end
        end
        DV_CONVERT_START_N: begin
          cnt_q <= cnt_q + 16'h0001;
          if (convert_start_n_end) begin
            st_q <= DV_IDLE;
          end
        end
        default: st_q <= DV_IDLE;
      endcase
    end
  end

  // busy low while converting, high on completion [R11]
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_q <= adcsr_pkg::BUSY_RST;
    end else if (convert_start_n_end) begin
      busy_q <= 1'b1;                                   // [R11]
    end else if (convert_start_n_go) begin
      busy_q <= 1'b0;                                   // [R11]
    end
  end

  // result held until the next completion, previous one served meanwhile
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      result_q <= 12'h000;
    end else if (convert_start_n_end) begin
      result_q <= convert_start_n_sample;                          // [R13] [R5]
    end
  end

  // restarts the link shifter at conversion start and end, so a read
  // after busy falls serves the held word again; held while not slave
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clr_q  <= 1'b1;
      done_q <= 1'b0;
    end else begin
      clr_q  <= convert_start_n_end | convert_start_n_go | ~sel_q;            // [R1] [R5]
      done_q <= convert_start_n_end;
    end
  end

  assign convert_start_n_done = done_q;
  assign link.busy = busy_q;

  // ****************************************************************
  // link domain shifter on the host clock
  // ****************************************************************
  // result_q is quiet while the shifter runs: it only changes together
  // with the clear pulse, so the word is taken as a stable bus
  logic [3:0] bit_q;
  logic       sdo_q;

  wire more_bits = (bit_q < 4'(adcsr_pkg::RES_BITS));

  always_ff @(posedge link.shift_clock_pin or posedge clr_q) begin
    if (clr_q) begin
      bit_q <= 4'h0;
      sdo_q <= 1'b0;
    end else if (more_bits) begin
      sdo_q <= adcsr_pkg::result_bit(result_q, bit_q);  // [R2] [R13] [R10]
      bit_q <= bit_q + 4'h1;                            // [R2]
    end else begin
      sdo_q <= 1'b0;
    end
  end

  assign link.serial_result_out = sdo_q;

endmodule

// ****************************************************************
// result buffer, valid/ready on both sides
// ****************************************************************
module adcsr_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;

  wire full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push  = in_valid & ~full;
  wire pop   = out_valid & out_ready;

  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + (AW+1)'(1);
      end
      if (pop) begin
        rd_q <= rd_q + (AW+1)'(1);
      end
    end
  end

endmodule

// ==== logic/adcsr_host.sv ====
`timescale 1ns/1ps
// What this block does
// R1 - select pin high makes device a clock slave
// R2 - device advances output bit on rising clock
// R3 - host idles clock low, samples on fall
// R4 - rising-edge sampling needs thirteen clock pulses
// R5 - read after busy falls gives previous result
// R6 - early read completes before busy rises again
// R7 - preferred: read after busy rises, clock quiet
// R8 - byte-limited hosts use slave mode as master
// R9 - byte host uses two 8-bit transfers
// R10 - eight msbs first, four lsbs next byte
// R11 - busy low during conversion, high when done
// R12 - host inputs quiet from 8 us on
// R13 - result held until next completion, msb first
module adcsr_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic        fall_mode,
  input  wire logic        rise_capture,
  input  wire logic        byte_mode,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [11:0]      out_data,
  output logic             late_error,
  adcsr_if.host            link
);

  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_WAIT_FALL, HS_WAIT_RISE, HS_SHIFT, HS_GAP, HS_PUSH
  } adcsr_host_state_type;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic bz_meta_q, bz_sync_q, bz_prev_q;
  logic sd_meta_q, sd_sync_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bz_meta_q <= adcsr_pkg::BUSY_RST;
      bz_sync_q <= adcsr_pkg::BUSY_RST;
      bz_prev_q <= adcsr_pkg::BUSY_RST;
      sd_meta_q <= 1'b0;
      sd_sync_q <= 1'b0;
    end else begin
      bz_meta_q <= link.busy;
      bz_sync_q <= bz_meta_q;
      bz_prev_q <= bz_sync_q;
      sd_meta_q <= link.serial_result_out;
      sd_sync_q <= sd_meta_q;
    end
  end

  wire busy_fell = bz_prev_q & ~bz_sync_q;
  wire busy_rose = ~bz_prev_q & bz_sync_q;

  // ****************************************************************
  // state, timers and modes
  // ****************************************************************
  adcsr_host_state_type st_q, st_d;
  logic [10:0] cnt_q;
  logic [10:0] elapsed_q;
  logic [2:0]  half_q;
  logic        sclk_q;
  logic [4:0]  falls_q;
  logic [4:0]  rises_q;
  logic [11:0] rx_q;
  logic [3:0]  got_q;
  logic        convert_start_n_n_q;
  logic        late_q;
  logic        fall_q, rcap_q, byte_q;
  logic        fifo_ready;

  // byte hosts sample on the falling edge only
  wire       rcap   = rcap_q & ~byte_q;
  wire [4:0] n_clk  = rcap   ? 5'(adcsr_pkg::CLK_RISE) :
                      byte_q ? 5'(adcsr_pkg::CLK_BYTE) :
                               5'(adcsr_pkg::CLK_FALL);
  wire in_shift     = (st_q == HS_SHIFT);
  wire tick         = in_shift && (half_q == 3'(adcsr_pkg::HOST_HALF - 1));
  wire rise_ev      = tick & ~sclk_q;
  wire fall_ev      = tick & sclk_q;
  wire need_bits    = (got_q < 4'(adcsr_pkg::RES_BITS));
  wire capture      = need_bits & (rcap ? (rise_ev & (rises_q != 5'h00)) : fall_ev);
  wire last_fall    = fall_ev && (falls_q == n_clk - 5'h01);
  wire byte_pause   = byte_q && fall_ev && (falls_q == 5'(adcsr_pkg::BYTE_BITS - 1));
  wire late_win     = elapsed_q >= 11'(adcsr_pkg::QUIET_CYC);
  wire late         = fall_q && late_win && (in_shift || st_q == HS_GAP);
  wire start_done   = cnt_q == 11'(adcsr_pkg::CONVERT_START_N_LOW_CYC - 1);
  wire gap_done     = cnt_q == 11'(adcsr_pkg::BYTE_GAP_CYC - 1);

  always_comb begin
    st_d = st_q;
    case (st_q)
      HS_IDLE: begin
        if (run) begin
          st_d = HS_START;
        end
      end
      HS_START: begin
        if (start_done) begin
          st_d = HS_WAIT_FALL;
        end
      end
      HS_WAIT_FALL: begin
        if (busy_fell) begin
          st_d = fall_q ? HS_SHIFT : HS_WAIT_RISE;    // [R5] [R7]
        end
      end
      HS_WAIT_RISE: begin
        if (busy_rose) begin
          st_d = HS_SHIFT;                            // [R7]
        end
      end
      HS_SHIFT: begin
        if (late) begin
          st_d = HS_IDLE;                             // [R6] [R12]
        end else if (last_fall) begin
          st_d = HS_PUSH;
        end else if (byte_pause) begin
          st_d = HS_GAP;                              // [R9]
        end
      end
      HS_GAP: begin
        if (late) begin
          st_d = HS_IDLE;                             // [R6]
        end else if (gap_done) begin
          st_d = HS_SHIFT;                            // [R9]
        end
      end
      HS_PUSH: begin
        if (fifo_ready) begin
          st_d = HS_IDLE;
        end
      end
      default: st_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q  <= HS_IDLE;
      cnt_q <= 11'h000;
    end else begin
      st_q  <= st_d;
      cnt_q <= (st_d != st_q) ? 11'h000 : cnt_q + 11'h001;
    end
  end

  // time since the conversion request, saturating
  always_ff @(posedge sys_clk) begin
    if (!rst_n || st_q == HS_IDLE) begin
      elapsed_q <= 11'h000;
    end else if (!late_win) begin
      elapsed_q <= elapsed_q + 11'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fall_q <= 1'b0;
      rcap_q <= 1'b0;
      byte_q <= 1'b0;
    end else if (st_q == HS_IDLE && run) begin
      fall_q <= fall_mode;
      rcap_q <= rise_capture;
      byte_q <= byte_mode;                            // [R8]
    end
  end

  // ****************************************************************
  // serial clock generation, idle low
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !in_shift) begin
      half_q <= 3'h0;
      sclk_q <= adcsr_pkg::SCLK_RST;                  // [R3] [R7]
    end else begin
      half_q <= tick ? 3'h0 : half_q + 3'h1;
      sclk_q <= tick ? ~sclk_q : sclk_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || st_q == HS_IDLE) begin
      falls_q <= 5'h00;
      rises_q <= 5'h00;
    end else begin
      falls_q <= fall_ev ? falls_q + 5'h01 : falls_q; // [R4] [R9]
      rises_q <= rise_ev ? rises_q + 5'h01 : rises_q;
    end
  end

  // ****************************************************************
  // receive, msb first
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n || st_q == HS_IDLE) begin
      rx_q  <= 12'h000;
      got_q <= 4'h0;
    end else if (capture) begin
      rx_q  <= {rx_q[10:0], sd_sync_q};               // [R3] [R4] [R10]
      got_q <= got_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      convert_start_n_n_q <= adcsr_pkg::CONVERT_START_N_RST;
      late_q   <= 1'b0;
    end else begin
      convert_start_n_n_q <= (st_d != HS_START);
      late_q   <= late;                               // [R6]
    end
  end

  assign link.shift_clock_pin = sclk_q;
  assign link.convert_start_n = convert_start_n_n_q;
  assign late_error           = late_q;

  // ****************************************************************
  // result buffer
  // ****************************************************************
  adcsr_fifo #(
    .WIDTH (adcsr_pkg::RES_BITS),
    .DEPTH (adcsr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (st_q == HS_PUSH),
    .in_ready  (fifo_ready),
    .in_data   (rx_q),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

endmodule

// ==== verification/adcsr_asserts.sv ====
`timescale 1ns/1ps
module adcsr_asserts #(
  parameter int CONVERT_START_N_CYCLES = 300
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic shift_clock_pin,
  input wire logic serial_result_out,
  input wire logic busy,
  input wire logic convert_start_n
);
  // ********
  // helpers
  // ********
  int low_cnt_q;
  int quiet_cnt_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      low_cnt_q   <= 0;
      quiet_cnt_q <= 0;
    end else begin
      low_cnt_q   <= busy ? 0 : low_cnt_q + 1;
      quiet_cnt_q <= shift_clock_pin ? 0 : ((quiet_cnt_q < 255) ? quiet_cnt_q + 1 : quiet_cnt_q);
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ********
  // link properties
  // ********
  sequence s_start_low;
    !convert_start_n [*4] ##1 convert_start_n;
  endsequence

  sequence s_sclk_cycle;
    shift_clock_pin [*4] ##1 !shift_clock_pin [*4];
  endsequence

  property p_start_pulse;
    $fell(convert_start_n) |-> s_start_low;
  endproperty
  property p_busy_follows;
    $fell(convert_start_n) |-> ##[1:5] $fell(busy);
  endproperty
  property p_busy_cause;
    $fell(busy) |-> !$past(convert_start_n, 2);
  endproperty
  property p_convert_start_n_length;
    $rose(busy) |-> (low_cnt_q >= CONVERT_START_N_CYCLES - 1) && (low_cnt_q <= CONVERT_START_N_CYCLES + 1);
  endproperty
  property p_quiet_finish;
    $rose(busy) |-> !shift_clock_pin && (quiet_cnt_q >= 8);
  endproperty
  property p_sdo_rise;
    $rose(serial_result_out) |-> shift_clock_pin;
  endproperty
  property p_sclk_shape;
    $rose(shift_clock_pin) |-> s_sclk_cycle;
  endproperty
  property p_no_clock_in_start;
    !convert_start_n |-> !shift_clock_pin;
  endproperty

  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse width wrong");
  a_busy_follows: assert property (p_busy_follows)
    else $error("busy did not fall after start");
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy fell without start");
  a_convert_start_n_length: assert property (p_convert_start_n_length)
    else $error("conversion length wrong");
  a_quiet_finish: assert property (p_quiet_finish)
    else $error("shift clock active at conversion end");
  a_sdo_rise: assert property (p_sdo_rise)
    else $error("data changed away from rising clock");
  a_sclk_shape: assert property (p_sclk_shape)
    else $error("shift clock shape wrong");
  a_no_clock_in_start: assert property (p_no_clock_in_start)
    else $error("shift clock during start");
endmodule

// ==== verification/adc_serial_slave_readout_bench.sv ====
`timescale 1ns/1ps
module adc_serial_slave_readout_bench;
  // ********
  // wiring
  // ********
  localparam int       CONVERT_START_N_CYC = 300;
  localparam bit [0:5] FM       = 6'h03;
  localparam bit [0:5] RC       = 6'h28;
  localparam bit [0:5] BM       = 6'h19;
  localparam bit [0:5] SL       = 6'h3b;
  logic        sys_clk             = 1'b0;
  logic        rst_n               = 1'b0;
  logic        run                 = 1'b0;
  logic        fall_mode           = 1'b0;
  logic        rise_capture        = 1'b0;
  logic        byte_mode           = 1'b0;
  logic        out_ready           = 1'b0;
  logic        clock_source_select = 1'b1;
  logic [11:0] convert_start_n_sample         = 12'ha5c;
  logic        convert_start_n_done;
  logic        out_valid;
  logic [11:0] out_data;
  logic        late_error;
  logic [11:0] latched[$];
  int          err_total = 0;
  int          checks    = 0;
  int          late_cnt  = 0;
  int          edge_cnt  = 0;

  adcsr_if link_if ();

  adcsr_device #(.CONVERT_START_N_CYCLES(CONVERT_START_N_CYC)) adcsr_device_i (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .clock_source_select (clock_source_select),
    .convert_start_n_sample         (convert_start_n_sample),
    .convert_start_n_done           (convert_start_n_done),
    .link                (link_if)
  );

  adcsr_host adcsr_host_i (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .run          (run),
    .fall_mode    (fall_mode),
    .rise_capture (rise_capture),
    .byte_mode    (byte_mode),
    .out_valid    (out_valid),
    .out_ready    (out_ready),
    .out_data     (out_data),
    .late_error   (late_error),
    .link         (link_if)
  );

  adcsr_asserts #(.CONVERT_START_N_CYCLES(CONVERT_START_N_CYC)) adcsr_asserts_i (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .shift_clock_pin   (link_if.shift_clock_pin),
    .serial_result_out (link_if.serial_result_out),
    .busy              (link_if.busy),
    .convert_start_n   (link_if.convert_start_n)
  );

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // records each latched sample, then moves the converter input on
  always @(posedge sys_clk) begin
    if (convert_start_n_done === 1'b1) begin
      latched.push_back(convert_start_n_sample);
      convert_start_n_sample <= convert_start_n_sample + 12'h5a7;
    end
    if (late_error === 1'b1) begin
      late_cnt++;
    end
  end

  always @(posedge link_if.shift_clock_pin) begin
    edge_cnt++;
  end

  // ********
  // tasks
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cmp_count(input int got, input int exp);
    checks++;
    if (got != exp) begin
      err_total++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wait_convert_start_n(input int n);
    int w;
    w = 0;
    while (latched.size() < n && w < 8000) begin
      tick(1);
      w++;
    end
    if (latched.size() < n) begin
      err_total++;
      $display("ERROR %0t conversion wait expired", $time);
    end
  endtask

  // waits for a buffered word, checks it, then pops it
  task automatic pop_word(input int idx, input bit zero);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    while (out_valid !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmp_bit(out_valid, 1'b1);
    cmp_word(out_data, zero ? 12'h000 : latched[idx]);
    @(posedge sys_clk) out_ready <= 1'b1;
    @(posedge sys_clk) out_ready <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ********
  // tests
  // ********
  initial begin
    tick(40000);
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    int n0;
    tick(20);
    rst_n <= 1'b1;
    tick(2);
    // fill the buffer with the reader stalled, then drain it
    run <= 1'b1;
    wait_convert_start_n(9);
    tick(800);
    cmp_count(latched.size(), 9);
    run <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      pop_word(i, 1'b0);
    end
    tick(10);
    #1;
    cmp_bit(out_valid, 1'b0);
    // one read in each transfer mode
    for (int k = 0; k < 6; k++) begin
      n0 = latched.size();
      tick(1);
      fall_mode           <= FM[k];
      rise_capture        <= RC[k];
      byte_mode           <= BM[k];
      clock_source_select <= SL[k];
      tick(6);
      edge_cnt = 0;
      run <= 1'b1;
      tick(1);
      run <= 1'b0;
      pop_word(FM[k] ? n0 - 1 : n0, !SL[k]);
      wait_convert_start_n(n0 + 1);
      tick(20);
      cmp_count(edge_cnt, BM[k] ? adcsr_pkg::CLK_BYTE :
                (RC[k] ? adcsr_pkg::CLK_RISE : adcsr_pkg::CLK_FALL));
    end
    cmp_count(late_cnt, 0);
    tally_and_finish();
  end
endmodule
